// [core/acp_host_port.sv]
// Host port, control register and sequencer of the converter
`timescale 1ns/100ps
module acp_host_port
    import acp_pkg::*;
#(
    parameter int unsigned PWR_WAIT_CYC = PWR_WAIT_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host bus strobes and selects
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic control_register_select,
    input wire logic upper_byte_select,
    input wire logic [1:0] chan_addr,
    // Data bus, split three-state pin
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Calibration pin and supply monitor event
    input wire logic cal_n,
    input wire logic supply_fail,
    // Analog core side
    input wire logic comp_in,
    input wire logic cal_overflow,
    output logic [1:0] chan_sel,
    output logic busy_n,
    output logic power_down
);
    typedef struct packed {
        acp_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic mode_latched;
        logic pwr_down;
        logic pf_flag;
        logic cal_err;
        logic [RES_W-1:0] sar;
        logic [RES_W-1:0] res;
        logic [7:0] dout;
        logic oe_n;
        logic busy_n;
        logic wr_act;
        logic w_sel;
        logic w_hbe;
        logic [7:0] w_data;
        logic cal_prev_n;
        logic pf_prev;
        logic [1:0] chan;
    } acp_state_t;

    localparam acp_state_t ST_RST = '{
        phase: ST_WAIT, cnt: '0, mode_latched: 1'b0, pwr_down: 1'b0,
        pf_flag: 1'b0, cal_err: 1'b0, sar: RES_RST, res: RES_RST,
        dout: DOUT_RST, oe_n: 1'b1, busy_n: 1'b1, wr_act: 1'b0,
        w_sel: 1'b0, w_hbe: 1'b0, w_data: DOUT_RST, cal_prev_n: 1'b1,
        pf_prev: 1'b0, chan: 2'b00};

    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(PWR_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYC - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] SAMP_END = CNT_W'(SAMPLE_CYC);

    acp_state_t r_ff;
    acp_state_t nxt_r;
    logic [SYN_W-1:0] syn;
    logic s_cs_n, s_rd_n, s_wr_n, s_sel, s_hbe, s_cal_n, s_pf;
    logic [7:0] s_data;
    logic rd_int, wr_int, wr_end, cal_go, pf_ev, conv_go, sfr_wr;
    logic [7:0] status;
    logic [3:0] bit_idx;

    acp_sync #(
        .W(SYN_W),
        .RST_VAL(SYN_RST)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in({supply_fail, chan_addr, data_in, cal_n,
                 upper_byte_select, control_register_select,
                 wr_n, rd_n, cs_n}),
        .sync_out(syn)
    );

    assign s_cs_n = syn[SYN_CS];
    assign s_rd_n = syn[SYN_RD];
    assign s_wr_n = syn[SYN_WR];
    assign s_sel = syn[SYN_SEL];
    assign s_hbe = syn[SYN_HBE];
    assign s_cal_n = syn[SYN_CAL];
    assign s_data = syn[SYN_DATA +: 8];
    assign s_pf = syn[SYN_PF];

    assign rd_int = !s_cs_n && !s_rd_n && s_wr_n;
    assign wr_int = !s_cs_n && !s_wr_n;
    // act on the closing edge of write
    assign wr_end = r_ff.wr_act && !wr_int;
    assign sfr_wr = wr_end && r_ff.w_sel && r_ff.w_hbe;
    // pin edge or control bit 1
    assign cal_go = (!r_ff.cal_prev_n && s_cal_n)
                  || (sfr_wr && r_ff.w_data[BIT_CAL]);
    assign pf_ev = s_pf && !r_ff.pf_prev;
    // Reserved combination (select high, upper low) starts nothing
    assign conv_go = wr_end && (!r_ff.w_sel || r_ff.w_hbe);

    // status byte, reserved bits read zero
    always_comb begin
        status = 8'h00;
        status[BIT_MODE] = r_ff.mode_latched;
        status[BIT_CAL] = r_ff.phase == ST_CAL;
        status[BIT_PDOWN] = r_ff.pwr_down;
        status[BIT_PFAIL] = r_ff.pf_flag;
        status[BIT_CALERR] = r_ff.cal_err;
        status[BIT_BUSY] = (r_ff.phase == ST_CAL)
                         || (r_ff.phase == ST_CONV);
    end

    assign bit_idx = 4'(RES_MSB) - 4'(r_ff.cnt - SAMP_END);

    // Whole next-state of port, flags and sequencer
    always_comb begin
        nxt_r = r_ff;
        nxt_r.cal_prev_n = s_cal_n;
        nxt_r.pf_prev = s_pf;
        nxt_r.wr_act = wr_int;
        // Latch address and data while the strobe is low
        if (wr_int) begin
            nxt_r.w_sel = s_sel;
            nxt_r.w_hbe = s_hbe;
            nxt_r.w_data = s_data;
        end
        // mode and power-down from control write
        if (sfr_wr) begin
            nxt_r.mode_latched = r_ff.w_data[BIT_MODE];
            // bit 3 low or bit 1 exits
            nxt_r.pwr_down = r_ff.w_data[BIT_PDOWN]
                           && !r_ff.w_data[BIT_CAL];
            // low bit 5 clears supply flag
            if (!r_ff.w_data[BIT_PFAIL]) begin
                nxt_r.pf_flag = 1'b0;
            end
        end
        if (cal_go) begin
            nxt_r.pwr_down = 1'b0;
        end
        // Phase counter advances every cycle, held at zero in idle
        nxt_r.cnt = r_ff.cnt + 1'b1;
        case (r_ff.phase)
            ST_IDLE: begin
                nxt_r.cnt = '0;
            end
            ST_WAIT: begin
                if (r_ff.cnt == WAIT_LAST) begin
                    nxt_r.phase = ST_CAL;
                    nxt_r.cnt = '0;
                    nxt_r.cal_err = 1'b0;
                end
            end
            ST_CAL: begin
                if (cal_overflow) begin
                    nxt_r.cal_err = 1'b1;
                end
                if (r_ff.cnt == CAL_LAST) begin
                    nxt_r.phase = ST_CONV;
                    nxt_r.cnt = '0;
                end
            end
            // sample window then one decision a cycle
            ST_CONV: begin
                if (r_ff.cnt >= SAMP_END) begin
                    nxt_r.sar[bit_idx] = comp_in;
                    if (!r_ff.mode_latched) begin
                        nxt_r.res[bit_idx] = comp_in;
                    end
                end
                if (r_ff.cnt == CONV_LAST) begin
                    nxt_r.phase = ST_IDLE;
                    if (r_ff.mode_latched) begin
                        nxt_r.res = nxt_r.sar;
                    end
                end
            end
            default: begin
                nxt_r.phase = ST_IDLE;
            end
        endcase
        // also runs from power-down, flag stays
        if (conv_go && r_ff.phase == ST_IDLE) begin
            nxt_r.phase = ST_CONV;
            nxt_r.cnt = '0;
            nxt_r.sar = RES_RST;
            nxt_r.chan = syn[SYN_CHAN +: 2];
        end
        if (cal_go) begin
            nxt_r.phase = ST_CAL;
            nxt_r.cnt = '0;
            nxt_r.cal_err = 1'b0;
        end
        if (pf_ev) begin
            nxt_r.phase = ST_WAIT;
            nxt_r.cnt = '0;
            nxt_r.pf_flag = 1'b1;
            nxt_r.mode_latched = 1'b0;
            nxt_r.pwr_down = 1'b0;
        end
        nxt_r.busy_n = nxt_r.phase == ST_IDLE || nxt_r.phase == ST_WAIT;
        nxt_r.oe_n = !rd_int;
        nxt_r.dout = DOUT_RST;
        if (rd_int) begin
            if (s_sel) begin
                nxt_r.dout = s_hbe ? status : DOUT_RST;
            end else if (s_hbe) begin
                nxt_r.dout = {4'h0, r_ff.res[RES_MSB -: 4]};
            end else begin
                nxt_r.dout = r_ff.res[7:0];
            end
        end
    end

    // Single state register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= ST_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign data_out = r_ff.dout;
    assign data_oe_n = r_ff.oe_n;
    assign busy_n = r_ff.busy_n;
    assign chan_sel = r_ff.chan;
    assign power_down = r_ff.pwr_down;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_mode_write;
        sfr_wr && !pf_ev |=> r_ff.mode_latched == $past(r_ff.w_data[0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode bit not taken from control write");

    property p_latched_hold;
        r_ff.mode_latched && r_ff.phase == ST_CONV
            && r_ff.cnt != CONV_LAST |=> $stable(r_ff.res);
    endproperty
    a_latched_hold: assert property (p_latched_hold)
        else $error("latched result changed mid conversion");

    property p_status_read;
        rd_int && s_sel && s_hbe |=> !data_oe_n
            && data_out == $past(status);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status byte not driven on control read");

    property p_supply_fail;
        pf_ev |=> r_ff.pf_flag && !r_ff.mode_latched
            && r_ff.phase == ST_WAIT && busy_n;
    endproperty
    a_supply_fail: assert property (p_supply_fail)
        else $error("supply failure not handled");

    property p_cal_clear;
        cal_go && !pf_ev |=> r_ff.phase == ST_CAL && !r_ff.cal_err
            && !busy_n;
    endproperty
    a_cal_clear: assert property (p_cal_clear)
        else $error("calibration start did not clear error");

    property p_pdown;
        sfr_wr && r_ff.w_data[3] && !cal_go && !pf_ev |=> power_down;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down not entered");

    property p_idle_bus;
        s_cs_n |=> data_oe_n && data_out == 8'h00;
    endproperty
    a_idle_bus: assert property (p_idle_bus)
        else $error("bus driven while deselected");

    property p_busy_ignore;
        r_ff.phase == ST_CAL && r_ff.cnt < CAL_LAST && conv_go
            && !cal_go && !pf_ev |=> r_ff.phase == ST_CAL;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("conversion start accepted while busy");

    property p_hi_byte;
        rd_int && !s_sel && s_hbe |=>
            data_out == {4'h0, $past(r_ff.res[11:8])};
    endproperty
    a_hi_byte: assert property (p_hi_byte)
        else $error("wrong high result byte");

    property p_conv_len;
        r_ff.phase == ST_IDLE && conv_go && !cal_go && !pf_ev
            ##1 (!cal_go && !pf_ev) [*8] ##1 (!cal_go && !pf_ev) [*8]
            |=> !busy_n ##1 busy_n;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion is not 17 cycles");

    property p_cal_then_conv;
        r_ff.phase == ST_CAL && r_ff.cnt == CAL_LAST && !cal_go
            && !pf_ev |=> r_ff.phase == ST_CONV && r_ff.cnt == 0;
    endproperty
    a_cal_then_conv: assert property (p_cal_then_conv)
        else $error("calibration not followed by conversion");

    c_conv: cover property (r_ff.phase == ST_CONV
        && r_ff.cnt == CONV_LAST);
    c_sfr_read: cover property (rd_int && s_sel && s_hbe);
    c_pdown_conv: cover property (power_down && conv_go);
endmodule : acp_host_port

// [core/acp_pkg.sv]
// Constants and types for the converter host port and control register
package acp_pkg;
    // Sequencer timing in conversion clock cycles
    localparam int unsigned SAMPLE_CYC = 5;
    localparam int unsigned CONV_CYC = 17;
    localparam int unsigned CAL_CYC = 168;
    localparam int unsigned PWR_WAIT_DEF = 42425;
    localparam int CNT_W = 16;
    localparam int RES_W = 12;
    localparam int RES_MSB = 11;

    // Control register bit positions
    localparam int BIT_MODE = 0;
    localparam int BIT_CAL = 1;
    localparam int BIT_PDOWN = 3;
    localparam int BIT_PFAIL = 5;
    localparam int BIT_CALERR = 6;
    localparam int BIT_BUSY = 7;

    // Synchroniser lanes and their idle values
    localparam int SYN_W = 17;
    localparam int SYN_CS = 0;
    localparam int SYN_RD = 1;
    localparam int SYN_WR = 2;
    localparam int SYN_SEL = 3;
    localparam int SYN_HBE = 4;
    localparam int SYN_CAL = 5;
    localparam int SYN_DATA = 6;
    localparam int SYN_CHAN = 14;
    localparam int SYN_PF = 16;
    localparam logic [16:0] SYN_RST = 17'h00027;

    // Reset values of the output side
    localparam logic [7:0] DOUT_RST = 8'h00;
    localparam logic [11:0] RES_RST = 12'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CAL = 2'b10,
        ST_CONV = 2'b11
    } acp_phase_t;
endpackage : acp_pkg

// [core/acp_sync.sv]
// Two-flop synchroniser bank for the host port pins
`timescale 1ns/100ps
module acp_sync
    import acp_pkg::*;
#(
    parameter int W = SYN_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pin side and synchronised side
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } acp_sync_t;

    acp_sync_t r_ff;
    acp_sync_t nxt_r;

    // First stage feeds only the second stage
    always_comb begin
        nxt_r.meta = pin_in;
        nxt_r.sync = r_ff.meta;
    end

    // Both stages take the idle level under reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_ff <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sync_out = r_ff.sync;
endmodule : acp_sync

// [verification/acp_host_model.sv]
// Host processor model driving the converter bus port
`timescale 1ns/100ps
module acp_host_model (
    // Clock
    input wire logic sys_clk,
    // Strobes, selects and write data
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic control_register_select,
    output logic upper_byte_select,
    output logic [1:0] chan_addr,
    output logic [7:0] data_in,
    output logic cal_n,
    // Read side of the bus
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    // Idle bus, strobes and calibration pin high
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cal_n = 1'b1;
        control_register_select = 1'b0;
        upper_byte_select = 1'b0;
        chan_addr = 2'h0;
        data_in = 8'h00;
    end

    task automatic bus_read(input logic sel, input logic up,
                            output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hEE;
        @(negedge sys_clk);
        control_register_select = sel;
        upper_byte_select = up;
        cs_n = 1'b0;
        rd_n = 1'b0;
        // Answer taken mid-cycle, away from the launching edge
        do begin
            @(negedge sys_clk);
            n++;
        end while (data_oe_n !== 1'b0 && n < 12);
        if (data_oe_n === 1'b0) d = data_out;
        @(negedge sys_clk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : bus_read

    task automatic bus_write(input logic sel, input logic up,
                             input logic [1:0] ch, input logic [7:0] d);
        @(negedge sys_clk);
        control_register_select = sel;
        upper_byte_select = up;
        chan_addr = ch;
        data_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        wr_n = 1'b1;
        cs_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        // Released data line must not keep its old value
        data_in = ~d;
    endtask : bus_write

    task automatic cal_pulse();
        @(negedge sys_clk);
        cal_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        cal_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : cal_pulse
endmodule : acp_host_model

// [verification/acp_host_port_tb_top.sv]
// Self-checking testbench for the converter host port
`timescale 1ns/100ps
module acp_host_port_tb_top;
    import acp_pkg::*;
    logic sys_clk, reset_n, cs_n, rd_n, wr_n, sel, up, cal_n;
    logic supply_fail, comp_in, cal_overflow, data_oe_n, busy_n;
    logic power_down;
    logic [1:0] chan_addr, chan_sel;
    logic [7:0] data_in, data_out, rv;
    logic [15:0] cyc, t0;
    int bad_count, n_tests;

    // Short settling wait keeps the run brief
    acp_host_port #(.PWR_WAIT_CYC(20)) i_acp_host_port (
        .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .control_register_select(sel),
        .upper_byte_select(up), .chan_addr(chan_addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .cal_n(cal_n), .supply_fail(supply_fail), .comp_in(comp_in),
        .cal_overflow(cal_overflow), .chan_sel(chan_sel),
        .busy_n(busy_n), .power_down(power_down));

    acp_host_model i_acp_host_model (
        .sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .control_register_select(sel), .upper_byte_select(up),
        .chan_addr(chan_addr), .data_in(data_in), .cal_n(cal_n),
        .data_out(data_out), .data_oe_n(data_oe_n));

    // Clock and cycle count
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 16'h0001;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input logic s, input logic u, input logic [7:0] e);
        i_acp_host_model.bus_read(s, u, rv);
        check(s ? "status" : "result", {8'h00, rv}, {8'h00, e});
    endtask : rd_chk

    // Busy stretch length from t0, bounded wait
    task automatic wait_idle(input logic [15:0] e);
        int n;
        n = 0;
        while (busy_n !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check("busy length", cyc - t0, e);
    endtask : wait_idle

    task automatic wait_busy();
        int n;
        n = 0;
        while (busy_n !== 1'b0 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        t0 = cyc;
    endtask : wait_busy

    task automatic wr(input logic s, input logic [1:0] c, input logic [7:0] d);
        i_acp_host_model.bus_write(s, s, c, d);
        t0 = cyc;
    endtask : wr

    task automatic t_powerup();
        check("idle bus", {15'h0000, data_oe_n}, 16'h0001);
        wait_busy();
        rd_chk(1'b1, 1'b1, 8'h82);
        wait_idle(16'd185);
        rd_chk(1'b1, 1'b1, 8'h00);
        $display("done powerup");
    endtask : t_powerup

    task automatic t_transparent();
        comp_in = 1'b1;
        wr(1'b0, 2'h2, 8'h00);
        check("channel", {14'h0000, chan_sel}, 16'h0002);
        wait_idle(16'd17);
        rd_chk(1'b0, 1'b0, 8'hFF);
        rd_chk(1'b0, 1'b1, 8'h0F);
        $display("done transparent");
    endtask : t_transparent

    task automatic t_latched();
        wr(1'b1, 2'h0, 8'h01);
        wait_idle(16'd17);
        rd_chk(1'b1, 1'b1, 8'h01);
        rd_chk(1'b1, 1'b0, 8'h00);
        comp_in = 1'b0;
        wr(1'b0, 2'h1, 8'h00);
        rd_chk(1'b0, 1'b0, 8'hFF);
        wait_idle(16'd17);
        rd_chk(1'b0, 1'b0, 8'h00);
        $display("done latched");
    endtask : t_latched

    task automatic t_refuse();
        wr(1'b0, 2'h0, 8'h00);
        i_acp_host_model.bus_write(1'b0, 1'b0, 2'h3, 8'h00);
        check("channel", {14'h0000, chan_sel}, 16'h0000);
        wait_idle(16'd17);
        $display("done refuse");
    endtask : t_refuse

    task automatic t_powerdown();
        wr(1'b1, 2'h0, 8'h08);
        check("pdown", {15'h0000, power_down}, 16'h0001);
        wait_idle(16'd17);
        rd_chk(1'b1, 1'b1, 8'h08);
        wr(1'b0, 2'h0, 8'h00);
        wait_idle(16'd17);
        check("pdown", {15'h0000, power_down}, 16'h0001);
        wr(1'b1, 2'h0, 8'h01);
        check("pdown", {15'h0000, power_down}, 16'h0000);
        wait_idle(16'd17);
        wr(1'b1, 2'h0, 8'h09);
        wait_idle(16'd17);
        i_acp_host_model.cal_pulse();
        check("pdown", {15'h0000, power_down}, 16'h0000);
        wait_busy();
        wait_idle(16'd184);
        $display("done powerdown");
    endtask : t_powerdown

    task automatic t_cal();
        cal_overflow = 1'b1;
        i_acp_host_model.cal_pulse();
        wait_busy();
        rd_chk(1'b1, 1'b1, 8'hC3);
        cal_overflow = 1'b0;
        // Pin pulse returns one cycle after busy falls
        wait_idle(16'd184);
        rd_chk(1'b1, 1'b1, 8'h41);
        wr(1'b1, 2'h0, 8'h03);
        rd_chk(1'b1, 1'b1, 8'h83);
        wait_idle(16'd185);
        $display("done cal");
    endtask : t_cal

    task automatic t_supply();
        @(negedge sys_clk);
        supply_fail = 1'b1;
        repeat (3) @(negedge sys_clk);
        supply_fail = 1'b0;
        rd_chk(1'b1, 1'b1, 8'h20);
        wait_busy();
        wait_idle(16'd185);
        wr(1'b1, 2'h0, 8'h00);
        wait_idle(16'd17);
        rd_chk(1'b1, 1'b1, 8'h00);
        $display("done supply");
    endtask : t_supply

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog, well past the expected run
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        bad_count = 0;
        n_tests = 0;
        cyc = 16'h0000;
        t0 = 16'h0000;
        reset_n = 1'b0;
        supply_fail = 1'b0;
        comp_in = 1'b0;
        cal_overflow = 1'b0;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        t_powerup();
        t_transparent();
        t_latched();
        t_refuse();
        t_powerdown();
        t_cal();
        t_supply();
        print_verdict();
    end
endmodule : acp_host_port_tb_top
